// ### hw/programmable_threshold_stage.sv
// Bank of programmable protection stages with definite-time trip.
// Assumes measurements, block inputs and the register port share ref_clk_i.
//
// Overview of operation
// - Ten independent stages, own settings and state.
// - Each stage monitors one to three inputs.
// - Terms: above level, below level, rate.
// - Trip only when delay expires still picked.
// - Evaluation runs every five milliseconds.
// - Activated function exposes one to ten stages.
// - Stages beyond count stay inactive and hidden.
// - Exposed stage also needs its enable bit.
// - Enabled stage reports condition, expected, remaining time.
// - Not enabled stage reports disabled condition.
// - Setting group switches while stages keep running.
// - Phase current sources include harmonics, RMS, angle.
// - Above mode picks when signal exceeds level.
// - Release hysteresis relative to level, default three percent.
// - Condition is normal, started, tripped, blocked or disabled.
// - Release delay before started clears, default 60 ms.
`timescale 1ns/1ns
`include "pts_defs.svh"
module programmable_threshold_stage
  import pts_pkg::*;
#(
  parameter int NUM_STAGES  = `NUM_STAGES,
  parameter int NUM_SRC     = 64,
  parameter int EVAL_CYCLES = `EVAL_PERIOD_US * `CLK_FREQ_MHZ
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_i,
  input  wire logic [`ADDR_W-1:0]         addr_i,
  input  wire logic [`DATA_W-1:0]         wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic [`DATA_W-1:0]              rdata_o,
  input  wire logic [NUM_SRC*`DATA_W-1:0] meas_i,
  input  wire logic [NUM_STAGES-1:0]      block_i,
  output logic [NUM_STAGES-1:0]           start_o,
  output logic [NUM_STAGES-1:0]           trip_o,
  output logic                            irq_o
);
  localparam int DW = `DATA_W;
  localparam int TW = `TIME_W;
  localparam int CW = $clog2(EVAL_CYCLES + 1);
  localparam int EW = 2 * NUM_STAGES;
  localparam logic [DW-1:0] SET_RST [`SET_WORDS] =
    '{`CFG_RST, `LEVEL_RST, `HYST_RST, DW'(`OPDLY_RST), DW'(`RELDLY_RST)};

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [CW-1:0]        tcnt_r, tcnt_nxt;
  logic                 tick_r, tick_nxt;
  logic                 act_r, act_nxt;
  logic [3:0]           cnt_r;
  logic [3:0]           cnt_nxt;
  logic                 grp_r, grp_nxt;
  logic [3:0]           cnt_eff;
  logic [DW-1:0]        set_r   [2][NUM_STAGES][`SET_WORDS];
  logic [DW-1:0]        set_nxt [2][NUM_STAGES][`SET_WORDS];
  logic [DW-1:0]        cfg     [NUM_STAGES];
  logic [DW-1:0]        level   [NUM_STAGES];
  logic [DW-1:0]        hamt    [NUM_STAGES];
  logic [TW-1:0]        opdly   [NUM_STAGES];
  logic [TW-1:0]        reldly  [NUM_STAGES];
  logic [TW-1:0]        rlc_inc [NUM_STAGES];
  logic [NUM_STAGES-1:0] exposed, run, pick;
  stage_state_t         st_r    [NUM_STAGES];
  stage_state_t         st_nxt  [NUM_STAGES];
  logic [TW-1:0]        opc_r   [NUM_STAGES];
  logic [TW-1:0]        opc_nxt [NUM_STAGES];
  logic [TW-1:0]        rlc_r   [NUM_STAGES];
  logic [TW-1:0]        rlc_nxt [NUM_STAGES];
  cond_t                cond_r  [NUM_STAGES];
  cond_t                cond_nxt[NUM_STAGES];
  logic [TW-1:0]        rem_r   [NUM_STAGES];
  logic [TW-1:0]        rem_nxt [NUM_STAGES];
  logic [NUM_STAGES-1:0] start_nxt, trip_nxt;
  logic [EW-1:0]        stat_r;
  logic [EW-1:0]        stat_nxt;
  logic [EW-1:0]        mask_r;
  logic [EW-1:0]        mask_nxt;
  logic                 irq_nxt;
  logic [DW-1:0]        rdata_nxt;
  logic                 a_grp;
  logic [3:0]           a_stg;
  logic [2:0]           a_k;
  logic                 a_stg_ok;

  assign a_grp = addr_i[7];
  assign a_stg = addr_i[6:3];
  assign a_k   = addr_i[2:0];
  assign a_stg_ok = (int'(a_stg) < NUM_STAGES) && exposed[a_stg];

  ////////////////////////////////////////////////////////////////////////////
  // Evaluation tick, one pulse per period.
  always_comb begin
    tick_nxt = 1'b0;
    tcnt_nxt = tcnt_r + 1'b1;
    if (tcnt_r == CW'(EVAL_CYCLES - 1)) begin
      tcnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tcnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control word and the two setting groups.
  always_comb begin
    act_nxt = act_r;
    cnt_nxt = cnt_r;
    grp_nxt = grp_r;
    if (wr_i && addr_i == `ADR_CTRL) begin
      act_nxt = wdata_i[`CTRL_ACT];
      cnt_nxt = wdata_i[`CTRL_CNT_LSB +: 4];
      grp_nxt = wdata_i[`CTRL_GRP];
    end
  end

  // A count outside one to ten is clamped rather than rejected.
  always_comb begin
    cnt_eff = cnt_r;
    if (cnt_r == 4'h0) begin
      cnt_eff = 4'h1;
    end else if (int'(cnt_r) > NUM_STAGES) begin
      cnt_eff = 4'(NUM_STAGES);
    end
  end

  always_comb begin
    set_nxt = set_r;
    // Either group may be rewritten while the other one is live.
    if (wr_i && addr_i[9:8] == `ADR_SET_PAGE && a_stg_ok && int'(a_k) < `SET_WORDS) begin
      set_nxt[a_grp][a_stg][a_k] = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      act_r <= 1'b0;
      cnt_r <= 4'h1;
      grp_r <= 1'b0;
      for (int g = 0; g < 2; g++) begin
        for (int s = 0; s < NUM_STAGES; s++) begin
          for (int k = 0; k < `SET_WORDS; k++) begin
            set_r[g][s][k] <= SET_RST[k];
          end
        end
      end
    end else begin
      act_r <= act_nxt;
      cnt_r <= cnt_nxt;
      grp_r <= grp_nxt;
      set_r <= set_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage instances: settings of the live group feed three terms each.
  for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
    logic [1:0]     n_sel;
    logic [2:0]     pk;
    logic [2:0]     used;
    logic [DW-1:0]  lvl_abs;
    logic [DW+`HYST_W-1:0] prod;

    assign cfg[s]    = set_r[grp_r][s][`SET_CFG];
    assign level[s]  = set_r[grp_r][s][`SET_LEVEL];
    assign opdly[s]  = set_r[grp_r][s][`SET_OPDLY][TW-1:0];
    assign reldly[s] = set_r[grp_r][s][`SET_RELDLY][TW-1:0];
    assign exposed[s] = act_r && (s < int'(cnt_eff));
    assign run[s] = exposed[s] && cfg[s][`CFG_EN] && !block_i[s];
    assign rlc_inc[s] = rlc_r[s] + 1'b1;

    // Hysteresis is a share of the level's magnitude, in 0.01 % steps.
    assign lvl_abs = level[s][DW-1] ? DW'(-level[s]) : level[s];
    assign prod = lvl_abs * set_r[grp_r][s][`SET_HYST][`HYST_W-1:0];
    assign hamt[s] = DW'(prod / `HYST_SCALE);

    assign n_sel = cfg[s][`CFG_N_LSB +: 2];
    assign used = (n_sel == 2'd3) ? 3'b111 : (n_sel == 2'd2) ? 3'b011 : 3'b001;
    assign pick[s] = |(pk & used);

    for (genvar t = 0; t < 3; t++) begin : g_term
      term_compare #(
        .NUM_SRC (NUM_SRC),
        .W       (DW)
      ) u_term (
        .ref_clk_i  (ref_clk_i),
        .reset_i    (reset_i),
        .tick_i     (tick_r),
        .run_i      (run[s] && used[t]),
        .term_i     (term_t'(cfg[s][`CFG_TERM_LSB + 2*t +: 2])),
        .sel_i      (cfg[s][`CFG_SEL_LSB + `SEL_W*t +: `SEL_W]),
        .level_i    (level[s]),
        .hyst_amt_i (hamt[s]),
        .meas_i     (meas_i),
        .pick_o     (pk[t])
      );
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-stage definite-time state machine, advanced on the tick, forced to normal at once when not running.
  always_comb begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      st_nxt[s]  = st_r[s];
      opc_nxt[s] = opc_r[s];
      rlc_nxt[s] = rlc_r[s];
      if (!run[s]) begin
        st_nxt[s]  = ST_NORMAL;
        opc_nxt[s] = opdly[s];
        rlc_nxt[s] = '0;
      end else if (tick_r) begin
        case (st_r[s])
          ST_NORMAL: begin
            opc_nxt[s] = opdly[s];
            rlc_nxt[s] = '0;
            if (pick[s]) begin
              st_nxt[s] = ST_STARTED;
            end
          end
          ST_STARTED, ST_TRIPPED: begin
            if (pick[s]) begin
              rlc_nxt[s] = '0;
              if (st_r[s] == ST_STARTED) begin
                if (opc_r[s] <= TW'(1)) begin
                  st_nxt[s]  = ST_TRIPPED;
                  opc_nxt[s] = '0;
                end else begin
                  opc_nxt[s] = opc_r[s] - 1'b1;
                end
              end
            end else if (rlc_inc[s] >= reldly[s]) begin
              st_nxt[s]  = ST_NORMAL;
              opc_nxt[s] = opdly[s];
              rlc_nxt[s] = '0;
            end else begin
              rlc_nxt[s] = rlc_inc[s];
            end
          end
          default: begin
            st_nxt[s] = ST_NORMAL;
          end
        endcase
      end
    end
  end

  // Reported condition and outputs follow the next state, so they never lag.
  always_comb begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      start_nxt[s] = run[s] && (st_nxt[s] != ST_NORMAL);
      trip_nxt[s]  = run[s] && (st_nxt[s] == ST_TRIPPED);
      rem_nxt[s]   = (run[s] && st_nxt[s] == ST_STARTED) ? opc_nxt[s] : '0;
      if (!exposed[s] || !cfg[s][`CFG_EN]) begin
        cond_nxt[s] = COND_DISABLED;
      end else if (block_i[s]) begin
        cond_nxt[s] = COND_BLOCKED;
      end else begin
        case (st_nxt[s])
          ST_STARTED: cond_nxt[s] = COND_STARTED;
          ST_TRIPPED: cond_nxt[s] = COND_TRIPPED;
          default:    cond_nxt[s] = COND_NORMAL;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int s = 0; s < NUM_STAGES; s++) begin
        st_r[s]   <= ST_NORMAL;
        opc_r[s]  <= TW'(`OPDLY_RST);
        rlc_r[s]  <= '0;
        cond_r[s] <= COND_DISABLED;
        rem_r[s]  <= '0;
      end
      start_o <= '0;
      trip_o  <= '0;
    end else begin
      st_r    <= st_nxt;
      opc_r   <= opc_nxt;
      rlc_r   <= rlc_nxt;
      cond_r  <= cond_nxt;
      rem_r   <= rem_nxt;
      start_o <= start_nxt;
      trip_o  <= trip_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts: start edges in the low half, trip edges in the high half.
  always_comb begin
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_i && addr_i == `ADR_IRQ_MASK) begin
      mask_nxt = wdata_i[EW-1:0];
    end
    if (wr_i && addr_i == `ADR_IRQ_STAT) begin
      stat_nxt = stat_nxt & ~wdata_i[EW-1:0];
    end
    // New edges are ORed in last so a clear in the same cycle loses.
    stat_nxt = stat_nxt | {trip_nxt & ~trip_o, start_nxt & ~start_o};
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_o  <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads: data stand for exactly one cycle after the strobe.
  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      if (addr_i == `ADR_CTRL) begin
        rdata_nxt[`CTRL_ACT] = act_r;
        rdata_nxt[`CTRL_CNT_LSB +: 4] = cnt_r;
        rdata_nxt[`CTRL_GRP] = grp_r;
      end else if (addr_i == `ADR_IRQ_STAT) begin
        rdata_nxt[EW-1:0] = stat_r;
      end else if (addr_i == `ADR_IRQ_MASK) begin
        rdata_nxt[EW-1:0] = mask_r;
      end else if (addr_i[9:8] == `ADR_SET_PAGE && a_stg_ok) begin
        if (int'(a_k) < `SET_WORDS) begin
          rdata_nxt = set_r[a_grp][a_stg][a_k];
        end
      end else if (addr_i[9:8] == `ADR_STS_PAGE && a_stg_ok && addr_i[7] == 1'b0) begin
        case (a_k)
          `STS_COND:   rdata_nxt[2:0] = cond_r[a_stg];
          `STS_REMAIN: rdata_nxt[TW-1:0] = rem_r[a_stg];
          `STS_EXPECT: rdata_nxt[TW-1:0] = cfg[a_stg][`CFG_EN] ? opdly[a_stg] : '0;
          default:     rdata_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end
endmodule : programmable_threshold_stage

// ### hw/pts_defs.svh
// Constants of the programmable threshold stage bank.
// Assumes a 50 MHz reference clock and word-addressed register port.
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH
`define CLK_FREQ_MHZ   50
`define EVAL_PERIOD_US 5000
`define EVAL_PERIOD_MS 5
`define NUM_STAGES     10
`define ADDR_W         10
`define DATA_W         32
`define TIME_W         19
`define SEL_W          6
`define HYST_W         14
`define HYST_SCALE     10000
`define HYST_RST       32'h0000_012c
`define OPDLY_MS       40
`define RELDLY_MS      60
`define OPDLY_RST      (`OPDLY_MS / `EVAL_PERIOD_MS)
`define RELDLY_RST     (`RELDLY_MS / `EVAL_PERIOD_MS)
`define LEVEL_RST      32'h0000_0000
`define CFG_RST        32'h0000_0002
`define ADR_CTRL       10'h000
`define ADR_IRQ_STAT   10'h001
`define ADR_IRQ_MASK   10'h002
`define ADR_SET_PAGE   2'h1
`define ADR_STS_PAGE   2'h2
`define SET_CFG        3'h0
`define SET_LEVEL      3'h1
`define SET_HYST       3'h2
`define SET_OPDLY      3'h3
`define SET_RELDLY     3'h4
`define SET_WORDS      5
`define STS_COND       3'h0
`define STS_REMAIN     3'h1
`define STS_EXPECT     3'h2
`define CTRL_ACT       0
`define CTRL_CNT_LSB   1
`define CTRL_GRP       5
`define CFG_EN         0
`define CFG_N_LSB      1
`define CFG_TERM_LSB   3
`define CFG_SEL_LSB    9
`define PH_SRC_STRIDE  14
`endif

// ### hw/pts_pkg.sv
// Types shared by the programmable threshold stage bank.
// Assumes pts_defs.svh holds every numeric constant.
package pts_pkg;
  typedef enum logic [1:0] {TERM_ABOVE, TERM_BELOW, TERM_RATE} term_t;
  typedef enum logic [1:0] {ST_NORMAL, ST_STARTED, ST_TRIPPED} stage_state_t;
  typedef enum logic [2:0] {
    COND_NORMAL, COND_STARTED, COND_TRIPPED, COND_BLOCKED, COND_DISABLED
  } cond_t;
  // Order of the per-phase current values inside one phase slot.
  typedef enum logic [3:0] {
    PH_FUND, PH_H2, PH_H3, PH_H4, PH_H5, PH_H7, PH_H9,
    PH_H11, PH_H13, PH_H15, PH_H17, PH_H19, PH_TRUE_RMS_VALUE, PH_ANGLE
  } phase_src_t;
endpackage : pts_pkg

// ### hw/term_compare.sv
// One pick-up term: selects a measurement and compares it with hysteresis.
// Assumes measurements are on the same clock and tick_i is a one-cycle pulse.
`timescale 1ns/1ns
`include "pts_defs.svh"
module term_compare
  import pts_pkg::*;
#(
  parameter int NUM_SRC = 64,
  parameter int W       = 32
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 reset_i,
  input  wire logic                 tick_i,
  input  wire logic                 run_i,
  input  wire term_t                term_i,
  input  wire logic [`SEL_W-1:0]    sel_i,
  input  wire logic signed [W-1:0]  level_i,
  input  wire logic [W-1:0]         hyst_amt_i,
  input  wire logic [NUM_SRC*W-1:0] meas_i,
  output logic                      pick_o
);
  logic signed [W-1:0] val;
  logic signed [W-1:0] prev_r;
  logic signed [W-1:0] prev_nxt;
  logic signed [W+1:0] metric;
  logic signed [W+1:0] lvl;
  logic signed [W+1:0] hamt;
  logic                pick_nxt;

  always_comb begin
    val = '0;
    if (int'(sel_i) < NUM_SRC) begin
      val = meas_i[int'(sel_i)*W +: W];
    end
    lvl  = (W+2)'(level_i);
    hamt = (W+2)'($signed({1'b0, hyst_amt_i}));
    // Rate of change is the step between two evaluation ticks.
    metric = (term_i == TERM_RATE) ? (W+2)'(val) - (W+2)'(prev_r) : (W+2)'(val);
    prev_nxt = tick_i ? val : prev_r;
    pick_nxt = pick_o;
    if (!run_i) begin
      pick_nxt = 1'b0;
    end else if (tick_i) begin
      if (term_i == TERM_BELOW) begin
        if (metric < lvl) begin
          pick_nxt = 1'b1;
        end else if (metric > lvl + hamt) begin
          pick_nxt = 1'b0;
        end
      end else begin
        if (metric > lvl) begin
          pick_nxt = 1'b1;
        end else if (metric < lvl - hamt) begin
          pick_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prev_r <= '0;
      pick_o <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      pick_o <= pick_nxt;
    end
  end
endmodule : term_compare

// ### tb/meas_source_model.sv
// Behavioural model of the measurement system feeding the stage bank.
// Assumes the bench updates one source at a time on ref_clk_i.
`timescale 1ns/1ns
module meas_source_model #(
  parameter int NUM_SRC = 64
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  set_i,
  input  wire logic [5:0]            idx_i,
  input  wire logic [31:0]           val_i,
  output logic      [NUM_SRC*32-1:0] meas_o
);
  // Each value holds like a refreshed measurement until the next update.
  logic [NUM_SRC*32-1:0] store = '0;
  assign meas_o = store;
  always @(posedge ref_clk_i) begin
    if (set_i) begin
      store[int'(idx_i)*32 +: 32] <= val_i;
    end
  end
endmodule : meas_source_model

// ### tb/programmable_threshold_stage_tb.sv
// Self-checking bench for the programmable threshold stage bank.
// Assumes a 20-cycle evaluation period so stage timing fits a short run.
`timescale 1ns/1ns
`include "pts_defs.svh"
module programmable_threshold_stage_tb
  import pts_pkg::*;
;
  localparam int EVC = 20;
  logic          ref_clk_i = 1'b0;
  logic          reset_i   = 1'b1;
  logic [9:0]    addr_i    = '0;
  logic [31:0]   wdata_i   = '0;
  logic          wr_i      = 1'b0;
  logic          rd_i      = 1'b0;
  logic [31:0]   rdata_o;
  logic [2047:0] meas;
  logic [9:0]    block_i   = '0;
  logic [9:0]    start_o;
  logic [9:0]    trip_o;
  logic          irq_o;
  logic          set_v     = 1'b0;
  logic [5:0]    set_idx   = '0;
  logic [31:0]   set_val   = '0;
  int            n_errors  = 0;
  int            total_checks = 0;
  int            seed      = 66;
  int            s0, mag, n;

  always #10 ref_clk_i = ~ref_clk_i;

  programmable_threshold_stage #(.EVAL_CYCLES(EVC)) i_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas), .block_i(block_i),
    .start_o(start_o), .trip_o(trip_o), .irq_o(irq_o));
  meas_source_model i_src (.ref_clk_i(ref_clk_i), .set_i(set_v), .idx_i(set_idx),
    .val_i(set_val), .meas_o(meas));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] sa(int g, int s, int k);
    return 10'(32'h100 + g * 32'h80 + s * 8 + k);
  endfunction : sa
  function automatic logic [9:0] ta(int s, int k);
    return 10'(32'h200 + s * 8 + k);
  endfunction : ta
  // Term tp sits on input tp; the other used inputs stay above-level terms.
  function automatic logic [31:0] cw(int nin, int tp, int s);
    return 32'(1 + nin * 2 + (tp << (3 + 2 * tp)) + (s << 9) + ((s + 1) << 15) + ((s + 2) << 21));
  endfunction : cw
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : ck
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input logic [9:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 ck(rdata_o, e);
  endtask : rc
  task automatic put(input int i, input int v);
    @(posedge ref_clk_i);
    set_v <= 1'b1; set_idx <= 6'(i); set_val <= 32'(v);
    @(posedge ref_clk_i);
    set_v <= 1'b0;
  endtask : put
  // Counts cycles until the chosen output of stage s reaches lvl, bounded by lim.
  task automatic wo(input int s, input bit tr, input logic lvl, input int lim, output int c);
    c = 0;
    while (((tr ? trip_o[s] : start_o[s]) !== lvl) && c < lim) begin
      @(posedge ref_clk_i); #1; c++;
    end
    ck(c < lim, 1);
  endtask : wo
  task automatic report_and_stop;
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #(20 * 12000);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    s0 = {$random(seed)} % 40;
    mag = 20 + {$random(seed)} % 1000;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rc(`ADR_CTRL, 32'(1 << `CTRL_CNT_LSB));
    rc(sa(0, 0, 0), 0);
    wr(`ADR_CTRL, 32'h1);
    rc(sa(0, 1, 0), 0);
    wr(`ADR_CTRL, 32'h1f);
    rc(sa(0, 9, 0), `CFG_RST);
    wr(`ADR_CTRL, 32'h5);
    rc(sa(0, 1, 2), `HYST_RST);
    rc(sa(0, 1, 3), `OPDLY_RST);
    rc(sa(0, 1, 4), `RELDLY_RST);
    rc(ta(0, 0), COND_DISABLED);
    rc(ta(0, 2), 0);
    wr(sa(0, 2, 1), 32'h7);
    rc(sa(0, 2, 1), 0);
    rc(10'h3ff, 0);
    wr(sa(0, 0, 1), 32'ha);
    wr(sa(0, 0, 3), 32'h2);
    wr(sa(0, 0, 4), 32'h3);
    wr(sa(0, 0, 0), cw(1, 0, s0));
    put(s0, mag);
    wo(0, 0, 1, 4 * EVC, n);
    rc(ta(0, 1), 2);
    wo(0, 1, 1, 4 * EVC, n);
    ck(n + 2, 2 * EVC);
    rc(ta(0, 0), COND_TRIPPED);
    rc(`ADR_IRQ_STAT, 32'h401);
    ck(irq_o, 0);
    wr(`ADR_IRQ_MASK, 32'h400);
    repeat (2) @(posedge ref_clk_i);
    #1 ck(irq_o, 1);
    wr(`ADR_IRQ_STAT, 32'h401);
    repeat (2) @(posedge ref_clk_i);
    #1 ck(irq_o, 0);
    @(posedge ref_clk_i);
    block_i[0] <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 ck(start_o[0], 0);
    rc(ta(0, 0), COND_BLOCKED);
    @(posedge ref_clk_i);
    block_i[0] <= 1'b0;
    wr(sa(1, 0, 1), 32'ha);
    wr(sa(1, 0, 3), 32'h3);
    wr(sa(1, 0, 0), cw(1, 0, s0));
    wr(`ADR_CTRL, 32'h25);
    rc(ta(0, 2), 3);
    wo(0, 1, 1, 10 * EVC, n);
    wr(`ADR_CTRL, 32'h5);
    put(s0, 0);
    wo(0, 0, 0, 6 * EVC, n);
    ck(n >= 2 * EVC, 1);
    rc(ta(0, 0), COND_NORMAL);
    wr(sa(0, 0, 4), 32'h1);
    wr(sa(0, 0, 3), 32'h64);
    for (int t = 0; t < 3; t++) begin
      wr(sa(0, 0, 1), t == 0 ? 32'ha : 32'h5);
      for (int k = 0; k < 3; k++) put(s0 + k, 0);
      put(s0 + t, t == 1 ? 20 : 0);
      wr(sa(0, 0, 0), cw(t == 0 ? 2 : 3, t, s0));
      repeat (8 * EVC) @(posedge ref_clk_i);
      #1 ck(start_o[0], 0);
      put(s0 + t, t == 1 ? 1 : mag);
      wo(0, 0, 1, 4 * EVC, n);
      put(s0 + t, t == 1 ? 20 : 0);
      wo(0, 0, 0, 8 * EVC, n);
    end
    wr(sa(0, 0, 1), 32'h3e8);
    wr(sa(0, 0, 0), cw(1, 0, s0));
    put(s0, 1100);
    wo(0, 0, 1, 4 * EVC, n);
    put(s0, 980);
    repeat (5 * EVC) @(posedge ref_clk_i);
    #1 ck(start_o[0], 1);
    put(s0, 960);
    wo(0, 0, 0, 5 * EVC, n);
    put(s0, 1100);
    wo(0, 0, 1, 4 * EVC, n);
    wr(`ADR_CTRL, 32'h4);
    repeat (3) @(posedge ref_clk_i);
    #1 ck(start_o, 0);
    rc(ta(0, 0), 0);
    report_and_stop();
  end
endmodule : programmable_threshold_stage_tb

// ### tb/pts_check_monitor.sv
// Concurrent checks on the top ports of the threshold stage bank.
// Assumes the bank, its register port and its stage outputs all run on ref_clk_i.
`timescale 1ns/1ns
`include "pts_defs.svh"
module pts_check_monitor #(
  parameter int NUM_STAGES  = 10,
  parameter int NUM_SRC     = 64,
  parameter int EVAL_CYCLES = 20
) (
  input wire logic                       ref_clk_i,
  input wire logic                       reset_i,
  input wire logic [`ADDR_W-1:0]         addr_i,
  input wire logic [`DATA_W-1:0]         wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [`DATA_W-1:0]         rdata_o,
  input wire logic [NUM_SRC*`DATA_W-1:0] meas_i,
  input wire logic [NUM_STAGES-1:0]      block_i,
  input wire logic [NUM_STAGES-1:0]      start_o,
  input wire logic [NUM_STAGES-1:0]      trip_o,
  input wire logic                       irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data not zero outside a read");
  chk_reset_quiet: assert property (disable iff (1'b0) reset_i |=>
    (start_o == '0 && trip_o == '0 && !irq_o && rdata_o == '0))
    else $error("outputs active during reset");
  chk_trip_started: assert property ((trip_o & ~start_o) == '0)
    else $error("trip without started");
  chk_trip_after_start: assert property
    (((trip_o & ~$past(trip_o)) & ~$past(start_o)) == '0)
    else $error("trip rose before the stage started");
  chk_trip_not_early: assert property ($rose(start_o[0]) |-> !trip_o[0] [*8])
    else $error("trip less than one evaluation period after start");
  chk_block_drops: assert property ((block_i != '0) ##1 (block_i != '0) |->
    ((start_o | trip_o) & block_i & $past(block_i)) == '0)
    else $error("blocked stage still active");
  chk_unmapped_zero: assert property (rd_i && addr_i == 10'h3ff |=> rdata_o == '0)
    else $error("unmapped read not zero");
  chk_hide_drops: assert property
    (wr_i && addr_i == `ADR_CTRL && !wdata_i[`CTRL_ACT] |-> ##2 (start_o | trip_o) == '0)
    else $error("stage active after function deactivated");
endmodule : pts_check_monitor

bind programmable_threshold_stage pts_check_monitor #(
  .NUM_STAGES(NUM_STAGES), .NUM_SRC(NUM_SRC), .EVAL_CYCLES(EVAL_CYCLES)
) i_mon (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas_i), .block_i(block_i),
  .start_o(start_o), .trip_o(trip_o), .irq_o(irq_o)
);
